/* File: rtl/umv_params.svh */
// umv_params.svh: offsets, field positions and sizes of the monitor value bank
// assumes: included by the package only; the bank module relies on its macros
`ifndef UMV_PARAMS_SVH
`define UMV_PARAMS_SVH
`define UMV_OFF_SELECTOR 12'h800
`define UMV_OFF_OCC_VALUE 12'h840
`define UMV_OFF_OCC_SNAP 12'h848
`define UMV_OFF_BW_VALUE 12'h860
`define UMV_OFF_BW_EVENT 12'h870
`define UMV_NOT_READY_FLAG_BIT 31
`define UMV_VALUE_MSB 30
`define UMV_MON_MSB 15
`define UMV_RIS_LSB 24
`define UMV_RIS_MSB 27
`define UMV_MON_IDX_W 2
`define UMV_RIS_IDX_W 1
`define UMV_SLOT_W 3
`define UMV_SLOTS 8
`define UMV_RIS_RESET 4'h0
`define UMV_MON_RESET 16'h0000
`define UMV_ZERO32 32'h00000000
`define UMV_ZERO31 31'h00000000
`define UMV_FRAC_W 16
`define UMV_FRAC_HALF 48'h000000008000
`define UMV_FRAC_MID 16'h8000
`endif

/* File: rtl/umv_pkg.sv */
// umv_pkg.sv: types of the monitor value bank
// assumes: umv_params.svh on the include path
package umv_pkg;
`include "umv_params.svh"
    typedef struct packed {
        logic wr;
        logic rd;
        logic secure;
        logic [11:0] addr;
        logic [31:0] wdata;
    } umv_req_t;
    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
    } umv_rsp_t;
    typedef struct packed {
        logic [3:0] resource_instance_selector;
        logic [15:0] mon;
    } umv_sel_t;
    typedef struct packed {
        logic notReady;
        logic [30:0] value;
    } umv_val_t;
    typedef enum logic [2:0] {
        UMV_IDLE = 3'h1,
        UMV_READ = 3'h2,
        UMV_WRITE = 3'h4
    } umv_state_t;
endpackage : umv_pkg

/* File: rtl/umv_value_bank.sv */
// umv_value_bank.sv: occupancy, snapshot and bandwidth value registers
// assumes: single-cycle page access strobes; measurement engines drive
// per-slot live values and a bandwidth event with byte counts
`timescale 1ns/100ps
module umv_value_bank
    import umv_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire umv_req_t req,
    output umv_rsp_t rsp,
    input wire logic monitoringPresent,
    input wire logic occupancyPresent,
    input wire logic occupancyReadonlyFlag,
    input wire logic resourceSelectionPresent,
    input wire logic scalingEnable,
    input wire logic [4:0] scaleShift,
    input wire logic [1:0] [`UMV_SLOTS-1:0] occLiveNotReady,
    input wire logic [1:0] [`UMV_SLOTS-1:0] [30:0] occLive,
    input wire logic captureEvent,
    input wire logic bwEvent,
    input wire logic bwEventSecure,
    input wire logic [`UMV_SLOT_W-1:0] bwEventSlot,
    input wire logic [15:0] bwEventBytes
);
    // ======================================================
    // selectors, one per security state
    umv_sel_t sel [2];
    umv_val_t occ [2][`UMV_SLOTS];
    umv_val_t snap [2][`UMV_SLOTS];
    umv_val_t bw [2][`UMV_SLOTS];
    logic [15:0] bwFrac [2][`UMV_SLOTS];
    umv_state_t state;
    logic s;
    logic [`UMV_SLOT_W-1:0] slot;
    logic occOn;
    logic [47:0] bwSum;

    function automatic logic [`UMV_SLOT_W-1:0] slot_of(umv_sel_t sl,
                                                       logic risOn);
        logic [`UMV_SLOT_W-1:0] r;
        r = {1'b0, sl.mon[`UMV_MON_IDX_W-1:0]};
        if (risOn) begin
            r[`UMV_SLOT_W-1] = sl.resource_instance_selector[0];
        end
        return r;
    endfunction : slot_of

    assign s = req.secure;
    assign slot = slot_of(sel[s], resourceSelectionPresent);
    assign occOn = monitoringPresent & occupancyPresent;

    // the fraction is signed: a total rounded up carries its debt forward
    function automatic logic [47:0] bw_total(logic [30:0] v,
                                             logic [15:0] f,
                                             logic [15:0] b,
                                             logic [4:0] sh);
        return {1'b0, v, 16'h0000} + {{32{f[15]}}, f}
            + 48'({b, 16'h0000} >> sh) + `UMV_FRAC_HALF;
    endfunction : bw_total

    assign bwSum = bw_total(bw[bwEventSecure][bwEventSlot].value,
                            bwFrac[bwEventSecure][bwEventSlot],
                            bwEventBytes, scaleShift);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2; i++) begin
                sel[i] <= '{resource_instance_selector: `UMV_RIS_RESET, mon: `UMV_MON_RESET};
            end
        end else if (req.wr && req.addr == `UMV_OFF_SELECTOR) begin
            sel[s].mon <= req.wdata[`UMV_MON_MSB:0];
            sel[s].resource_instance_selector <= resourceSelectionPresent ?
                req.wdata[`UMV_RIS_MSB:`UMV_RIS_LSB] : `UMV_RIS_RESET;
        end
    end

    // ======================================================
    // occupancy value and snapshot
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2; i++) begin
                for (int j = 0; j < `UMV_SLOTS; j++) begin
                    occ[i][j] <= '{notReady: 1'b1, value: `UMV_ZERO31};
                    snap[i][j] <= '{notReady: 1'b1, value: `UMV_ZERO31};
                end
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                for (int j = 0; j < `UMV_SLOTS; j++) begin
                    // software write wins over the live sample that cycle
                    occ[i][j] <= '{notReady: occLiveNotReady[i][j],
                                   value: occLive[i][j]};
                    if (captureEvent) begin
                        snap[i][j] <= occ[i][j];
                    end
                end
            end
            if (req.wr && occOn && !occupancyReadonlyFlag &&
                req.addr == `UMV_OFF_OCC_VALUE) begin
                occ[s][slot] <= req.wdata;
            end
            if (req.wr && occOn && req.addr == `UMV_OFF_OCC_SNAP) begin
                snap[s][slot] <= req.wdata;
            end
        end
    end

    // ======================================================
    // bandwidth counters; the fraction keeps the low bits shifted below the count so
    // rounding is on the running total, not per event
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2; i++) begin
                for (int j = 0; j < `UMV_SLOTS; j++) begin
                    bw[i][j] <= '{notReady: 1'b0, value: `UMV_ZERO31};
                    bwFrac[i][j] <= 16'h0000;
                end
            end
        end else begin
            // events go first, so a write to another slot cannot lose one
            if (bwEvent && scalingEnable) begin
                bw[bwEventSecure][bwEventSlot].value <=
                    31'(bwSum >> `UMV_FRAC_W);
                bwFrac[bwEventSecure][bwEventSlot] <=
                    16'(bwSum) - `UMV_FRAC_MID;
            end else if (bwEvent) begin
                bw[bwEventSecure][bwEventSlot].value <=
                    bw[bwEventSecure][bwEventSlot].value
                    + 31'(bwEventBytes);
            end
            // a write to the event's own slot still beats the event
            if (req.wr && monitoringPresent &&
                req.addr == `UMV_OFF_BW_VALUE) begin
                bw[s][slot] <= req.wdata;
                bwFrac[s][slot] <= 16'h0000;
            end
        end
    end

    // ======================================================
    // access sequencing and read data
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= UMV_IDLE;
            rsp <= '{valid: 1'b0, rdata: `UMV_ZERO32};
        end else begin
            rsp.valid <= req.rd | req.wr;
            state <= req.rd ? UMV_READ : (req.wr ? UMV_WRITE : UMV_IDLE);
            rsp.rdata <= `UMV_ZERO32;
            if (req.rd) begin
                case (req.addr)
                    `UMV_OFF_SELECTOR: begin
                        rsp.rdata <= {4'h0, sel[s].resource_instance_selector, 8'h00, sel[s].mon};
                    end
                    `UMV_OFF_OCC_VALUE: begin
                        rsp.rdata <= occOn ? occ[s][slot] : `UMV_ZERO32;
                    end
                    `UMV_OFF_OCC_SNAP: begin
                        rsp.rdata <= occOn ? snap[s][slot] : `UMV_ZERO32;
                    end
                    `UMV_OFF_BW_VALUE: begin
                        rsp.rdata <= monitoringPresent ?
                            bw[s][slot] : `UMV_ZERO32;
                    end
                    default: begin
                        rsp.rdata <= `UMV_ZERO32;
                    end
                endcase
            end
        end
    end

    // ======================================================
    // checks
    a_occ_absent_zero: assert property (@(posedge clock) disable iff (!rst_n)
        req.rd && !occOn && req.addr == `UMV_OFF_OCC_VALUE |=>
        rsp.rdata == `UMV_ZERO32) else $error("occupancy not zero");
    a_rsp_follows: assert property (@(posedge clock) disable iff (!rst_n)
        (req.rd || req.wr) |=> rsp.valid) else $error("no answer");
    a_sel_mon_load: assert property (@(posedge clock) disable iff (!rst_n)
        req.wr && req.addr == `UMV_OFF_SELECTOR |=>
        sel[$past(s)].mon == $past(req.wdata[`UMV_MON_MSB:0]))
        else $error("selector not loaded");
    a_ro_keeps: assert property (@(posedge clock) disable iff (!rst_n)
        req.wr && occupancyReadonlyFlag && !captureEvent &&
        req.addr == `UMV_OFF_OCC_VALUE |=>
        occ[$past(s)][$past(slot)] != $past(req.wdata) ||
        $past(req.wdata) == {$past(occLiveNotReady[s][slot]),
                             $past(occLive[s][slot])})
        else $error("read-only written");
    a_idle_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        !req.rd && !req.wr |=> !rsp.valid && rsp.rdata == `UMV_ZERO32)
        else $error("spurious answer");
    a_no_ris_slot: assert property (@(posedge clock) disable iff (!rst_n)
        !resourceSelectionPresent |-> slot[`UMV_SLOT_W-1] == 1'b0)
        else $error("resource bit leaked");
    a_bw_write: assert property (@(posedge clock) disable iff (!rst_n)
        req.wr && monitoringPresent && req.addr == `UMV_OFF_BW_VALUE |=>
        bw[$past(s)][$past(slot)] == $past(req.wdata))
        else $error("bandwidth write lost");
    a_snap_write: assert property (@(posedge clock) disable iff (!rst_n)
        req.wr && occOn && req.addr == `UMV_OFF_OCC_SNAP |=>
        snap[$past(s)][$past(slot)] == $past(req.wdata))
        else $error("snapshot write lost");
    a_write_no_data: assert property (@(posedge clock) disable iff (!rst_n)
        state == UMV_WRITE |-> rsp.rdata == `UMV_ZERO32)
        else $error("write answer carries data");
    a_capture_copy: assert property (
        @(posedge clock) disable iff (!rst_n)
        captureEvent && !req.wr |=>
        snap[$past(s)][$past(slot)] == $past(occ[s][slot]))
        else $error("snapshot not captured");
endmodule : umv_value_bank

/* File: dv/umv_value_bank_bench.sv */
// umv_value_bank_bench.sv: self-checking bench for the monitor value bank
// assumes: umv_pkg compiled first; bench drives every input port except clock at negedge
`timescale 1ns/100ps
module umv_value_bank_bench;
    import umv_pkg::*;
    logic clock;
    logic rst_n;
    umv_req_t req;
    umv_rsp_t rsp;
    logic monitoringPresent, occupancyPresent, occupancyReadonlyFlag;
    logic resourceSelectionPresent, scalingEnable;
    logic [4:0] scaleShift;
    logic [1:0] [7:0] occLiveNotReady;
    logic [1:0] [7:0] [30:0] occLive;
    logic captureEvent, bwEvent, bwEventSecure;
    logic [2:0] bwEventSlot;
    logic [15:0] bwEventBytes;
    logic [31:0] saved;
    int err_count;
    int checks_done;
    umv_value_bank dut (.clock(clock), .rst_n(rst_n), .req(req), .rsp(rsp),
        .monitoringPresent(monitoringPresent),
        .occupancyPresent(occupancyPresent),
        .occupancyReadonlyFlag(occupancyReadonlyFlag),
        .resourceSelectionPresent(resourceSelectionPresent),
        .scalingEnable(scalingEnable), .scaleShift(scaleShift),
        .occLiveNotReady(occLiveNotReady), .occLive(occLive),
        .captureEvent(captureEvent), .bwEvent(bwEvent),
        .bwEventSecure(bwEventSecure), .bwEventSlot(bwEventSlot),
        .bwEventBytes(bwEventBytes));
    // ==========================================================
    // clock, watchdog and helpers
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // about 60 cycles are needed; a hang is cut at 4000
    initial begin
        #(50 * 4000);
        err_count++;
        end_of_test();
    end
    task automatic end_of_test;
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // strobes stay up so back-to-back calls assign once per step
    task automatic acc(input logic w, input logic s, input logic [11:0] a,
                       input logic [31:0] d, input logic [31:0] exp);
        req.wr = w;
        req.rd = !w;
        req.secure = s;
        req.addr = a;
        req.wdata = d;
        @(negedge clock);
        check({31'h0, rsp.valid}, 32'h1);
        // writes answer with zero data, so every answer is compared
        check(rsp.rdata, exp);
    endtask : acc
    task automatic idle;
        req.wr = 1'b0;
        req.rd = 1'b0;
        @(negedge clock);
        check({31'h0, rsp.valid}, 32'h0);
        check(rsp.rdata, 32'h0);
    endtask : idle
    task automatic sel(input logic s, input logic [3:0] resource_instance_selector,
                       input logic [15:0] mon);
        acc(1'b1, s, 12'h800, {4'h0, resource_instance_selector, 8'h00, mon}, 32'h0);
    endtask : sel
    task automatic bw(input logic s, input logic [2:0] slot,
                      input logic [15:0] bytes);
        bwEvent = 1'b1;
        bwEventSecure = s;
        bwEventSlot = slot;
        bwEventBytes = bytes;
        @(negedge clock);
        bwEvent = 1'b0;
        @(negedge clock);
    endtask : bw
    function automatic logic [31:0] occ(input int s, input int i);
        return {occLiveNotReady[s][i], occLive[s][i]};
    endfunction : occ
    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        req = '0;
        {monitoringPresent, occupancyPresent} = 2'h3;
        {occupancyReadonlyFlag, scalingEnable} = 2'h0;
        resourceSelectionPresent = 1'b1;
        scaleShift = 5'h00;
        {captureEvent, bwEvent, bwEventSecure} = 3'h0;
        bwEventSlot = 3'h0;
        bwEventBytes = 16'h0000;
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 8; i++) begin
                occLiveNotReady[s][i] = 1'((i + s) % 2);
                occLive[s][i] = 31'(32'h100 * (i + 1) + 32'h10 * s);
            end
        end
        err_count = 0;
        checks_done = 0;
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        sel(1'b0, 4'h0, 16'h0001);
        acc(1'b0, 1'b0, 12'h840, 32'h0, occ(0, 1));
        sel(1'b0, 4'h1, 16'h0002);
        acc(1'b0, 1'b0, 12'h840, 32'h0, occ(0, 6));
        sel(1'b1, 4'h0, 16'h0003);
        acc(1'b0, 1'b1, 12'h840, 32'h0, occ(1, 3));
        acc(1'b0, 1'b0, 12'h840, 32'h0, occ(0, 6));
        resourceSelectionPresent = 1'b0;
        acc(1'b0, 1'b0, 12'h840, 32'h0, occ(0, 2));
        resourceSelectionPresent = 1'b1;
        idle();
        // capture, then move the live value so a stale copy shows
        saved = occ(0, 6);
        captureEvent = 1'b1;
        @(negedge clock);
        captureEvent = 1'b0;
        occLive[0][6] = 31'h0000abcd;
        idle();
        acc(1'b0, 1'b0, 12'h848, 32'h0, saved);
        acc(1'b1, 1'b0, 12'h848, 32'h80001234, 32'h0);
        acc(1'b0, 1'b0, 12'h848, 32'h0, 32'h80001234);
        occupancyReadonlyFlag = 1'b1;
        acc(1'b1, 1'b0, 12'h840, 32'h00000005, 32'h0);
        acc(1'b0, 1'b0, 12'h840, 32'h0, occ(0, 6));
        occupancyReadonlyFlag = 1'b0;
        acc(1'b1, 1'b0, 12'h840, 32'h00000005, 32'h0);
        acc(1'b0, 1'b0, 12'h840, 32'h0, 32'h00000005);
        for (int k = 0; k < 2; k++) begin
            {monitoringPresent, occupancyPresent} = k ? 2'h1 : 2'h2;
            acc(1'b0, 1'b0, 12'h840, 32'h0, 32'h0);
            acc(1'b0, 1'b1, 12'h848, 32'h0, 32'h0);
        end
        {monitoringPresent, occupancyPresent} = 2'h3;
        acc(1'b0, 1'b0, 12'h8f0, 32'h0, 32'h0);
        idle();
        // bandwidth: not-ready is clear from reset, only a write sets it
        bw(1'b0, 3'h6, 16'h0040);
        acc(1'b0, 1'b0, 12'h860, 32'h0, 32'h00000040);
        acc(1'b0, 1'b1, 12'h860, 32'h0, 32'h00000000);
        acc(1'b1, 1'b0, 12'h860, 32'h0, 32'h0);
        idle();
        scalingEnable = 1'b1;
        scaleShift = 5'h04;
        bw(1'b0, 3'h6, 16'h0020);
        acc(1'b0, 1'b0, 12'h860, 32'h0, 32'h00000002);
        acc(1'b1, 1'b1, 12'h860, 32'h80000055, 32'h0);
        acc(1'b0, 1'b1, 12'h860, 32'h0, 32'h80000055);
        acc(1'b0, 1'b0, 12'h860, 32'h0, 32'h00000002);
        idle();
        // second reset mid-run: selector and counter clear, snapshot returns to not-ready
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        idle();
        acc(1'b0, 1'b0, 12'h800, 32'h0, 32'h0);
        sel(1'b0, 4'h1, 16'h0002);
        acc(1'b0, 1'b0, 12'h848, 32'h0, 32'h80000000);
        acc(1'b0, 1'b0, 12'h860, 32'h0, 32'h0);
        idle();
        end_of_test();
    end
endmodule : umv_value_bank_bench
